// file: hdl/rofs_pkg.sv
// Constants, register map, bit positions and state encoding for the relay output fault-safe block
package rofs_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_CTRL     = 8'h00; // Link control and download
    localparam logic [7:0] ADDR_PARAM    = 8'h04; // Three staged parameter bytes
    localparam logic [7:0] ADDR_OUTDATA  = 8'h08; // Scan output data from master
    localparam logic [7:0] ADDR_READBACK = 8'h0c; // Relay read-back bits
    localparam logic [7:0] ADDR_STATUS   = 8'h10; // Live state
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14; // Sticky events, write one to clear
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18; // Interrupt enables
    localparam logic [7:0] ADDR_ACTIVE   = 8'h1c; // Parameters in force

    // Control register bit positions
    localparam int CTRL_LINK_UP  = 0; // Level: link alive
    localparam int CTRL_COMMIT   = 1; // Pulse: download finished
    localparam int CTRL_PARAM_OK = 2; // Staged parameter block is valid

    // Parameter block layout, byte 0 to byte 2
    localparam int PARAM_BYTES   = 3;
    localparam int PB_FAULT_SEL  = 0;  // Byte 0 bit 0
    localparam int PB_PRESET_LSB = 8;  // Byte 1 holds the presets
    localparam logic [23:0] PARAM_RESET = 24'h000000; // Hold, all presets open

    // Status bit positions
    localparam int ST_RUNNING = 0;
    localparam int ST_FAULT   = 1;
    localparam int ST_OUT_VAL = 2;

    // Event bits
    localparam int EV_INIT_OK  = 0;
    localparam int EV_INIT_BAD = 1;
    localparam int EV_LINK_LOS = 2;
    localparam int EV_LINK_RET = 3;
    localparam int EV_W        = 4;

    // Blink timing
    localparam longint CLK_HZ      = 250_000_000;
    localparam longint BLINK_PER_S = 4;
    localparam longint HALF_BLINK_CYC = CLK_HZ / (BLINK_PER_S * 2);

    // Link state
    typedef enum logic [1:0] {
        ROFS_WAIT  = 2'b00,
        ROFS_RUN   = 2'b01,
        ROFS_FAULT = 2'b11
    } rofs_state_t;
endpackage

// file: hdl/rofs_top.sv
// Eight-channel relay output slave with fault-safe outputs and link indicators
`timescale 1ns/1ps
module rofs_top #(
    parameter int          N_CH     = 8,
    parameter logic [31:0] HALF_CYC = 32'(rofs_pkg::HALF_BLINK_CYC)
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    input  wire logic [7:0]        i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    output logic      [N_CH-1:0]   o_relay_drive,
    output logic      [N_CH-1:0]   o_ch_led,
    output logic                   o_link_led,
    output logic                   o_irq
);
    // Event vector width, fixed by the package
    localparam int EVW = rofs_pkg::EV_W;

    // Register file
    logic [23:0]       param_stage_q;  // Staged block, not yet in force
    logic [23:0]       param_act_q;    // Block in force
    logic [N_CH-1:0]   out_data_q;     // Last output data from master
    logic              out_valid_q;    // First output data seen
    logic              link_up_q;      // Link level from protocol side
    logic              param_ok_q;     // Staged block valid flag
    logic [EVW-1:0]    irq_stat_q;     // Sticky events
    logic [EVW-1:0]    irq_mask_q;     // Event enables
    logic [N_CH-1:0]   relay_d;
    logic [31:0]       rdata_d;
    logic [31:0]       blink_cnt_q;
    logic              blink_q;
    logic [EVW-1:0]    ev;
    rofs_pkg::rofs_state_t state_q;

    // Decoded strobes
    logic wr_ctrl, wr_param, wr_out, wr_stat, wr_mask, commit;
    assign wr_ctrl  = i_wr && (i_addr == rofs_pkg::ADDR_CTRL);
    assign wr_param = i_wr && (i_addr == rofs_pkg::ADDR_PARAM);
    assign wr_out   = i_wr && (i_addr == rofs_pkg::ADDR_OUTDATA);
    assign wr_stat  = i_wr && (i_addr == rofs_pkg::ADDR_IRQ_STAT);
    assign wr_mask  = i_wr && (i_addr == rofs_pkg::ADDR_IRQ_MASK);
    assign commit   = wr_ctrl && i_wdata[rofs_pkg::CTRL_COMMIT];

    // Control levels; link drop takes effect immediately
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            link_up_q  <= 1'b0;
            param_ok_q <= 1'b0;
        end else if (wr_ctrl) begin
            link_up_q  <= i_wdata[rofs_pkg::CTRL_LINK_UP];
            param_ok_q <= i_wdata[rofs_pkg::CTRL_PARAM_OK];
        end
    end

    // Staging only; scans never read this copy
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            param_stage_q <= rofs_pkg::PARAM_RESET;
        end else if (wr_param) begin
            param_stage_q <= i_wdata[8*rofs_pkg::PARAM_BYTES-1:0];
        end
    end

    // Parameters latched once per good download, not per scan
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            param_act_q <= rofs_pkg::PARAM_RESET;
        end else if (commit && i_wdata[rofs_pkg::CTRL_PARAM_OK]) begin
            param_act_q <= param_stage_q;
        end
    end

    // Link state machine
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= rofs_pkg::ROFS_WAIT;
        end else begin
            case (state_q)
                rofs_pkg::ROFS_WAIT: begin
                    // Bad data keeps waiting
                    if (commit && i_wdata[rofs_pkg::CTRL_PARAM_OK]) begin
                        state_q <= rofs_pkg::ROFS_RUN;
                    end
                end
                rofs_pkg::ROFS_RUN: begin
                    if (!link_up_q) begin
                        state_q <= rofs_pkg::ROFS_FAULT;
                    end
                end
                rofs_pkg::ROFS_FAULT: begin
                    if (link_up_q) begin
                        state_q <= rofs_pkg::ROFS_RUN;
                    end
                end
                default: state_q <= rofs_pkg::ROFS_WAIT;
            endcase
        end
    end

    // Output data from master, accepted only while running
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            out_data_q  <= '0;
            out_valid_q <= 1'b0;
        end else if (wr_out && state_q == rofs_pkg::ROFS_RUN && link_up_q) begin
            out_data_q  <= i_wdata[N_CH-1:0]; // Channel one at bit 0
            out_valid_q <= 1'b1;
        end
    end

    // Relay choice; zero drive means open contact
    always_comb begin
        if (!out_valid_q) begin
            relay_d = '0;
        end else if (state_q == rofs_pkg::ROFS_FAULT &&
                     param_act_q[rofs_pkg::PB_FAULT_SEL]) begin
            relay_d = param_act_q[rofs_pkg::PB_PRESET_LSB +: N_CH];
        end else begin
            // Running follows data; fault with select 0 holds it
            relay_d = out_data_q;
        end
    end

    // Drives and channel LEDs share one source so they never disagree
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_relay_drive <= '0;
            o_ch_led      <= '0;
        end else begin
            o_relay_drive <= relay_d;
            o_ch_led      <= relay_d;
        end
    end

    // Blink divider: toggle every half period, four blinks per second
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q >= HALF_CYC - 32'h1) begin
            blink_cnt_q <= '0;
            blink_q     <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    // Link LED: steady only while running
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_link_led <= 1'b0;
        end else begin
            o_link_led <= (state_q == rofs_pkg::ROFS_RUN) ? 1'b1 : blink_q;
        end
    end

    // Events
    always_comb begin
        ev = '0;
        ev[rofs_pkg::EV_INIT_OK]  = commit && state_q == rofs_pkg::ROFS_WAIT &&
                                    i_wdata[rofs_pkg::CTRL_PARAM_OK];
        ev[rofs_pkg::EV_INIT_BAD] = commit && !i_wdata[rofs_pkg::CTRL_PARAM_OK];
        ev[rofs_pkg::EV_LINK_LOS] = state_q == rofs_pkg::ROFS_RUN && !link_up_q;
        ev[rofs_pkg::EV_LINK_RET] = state_q == rofs_pkg::ROFS_FAULT && link_up_q;
    end

    // Sticky status; a new event beats a same-cycle clear
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? i_wdata[EVW-1:0] : '0)) | ev;
        end
    end

    // Mask register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_mask_q <= '0;
        end else if (wr_mask) begin
            irq_mask_q <= i_wdata[EVW-1:0];
        end
    end

    // Level interrupt
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(((irq_stat_q & ~(wr_stat ? i_wdata[EVW-1:0] : '0)) | ev)
                       & (wr_mask ? i_wdata[EVW-1:0] : irq_mask_q));
        end
    end

    // Read mux; unmapped reads as zero
    always_comb begin
        rdata_d = '0;
        case (i_addr)
            rofs_pkg::ADDR_CTRL: begin
                rdata_d[rofs_pkg::CTRL_LINK_UP]  = link_up_q;
                rdata_d[rofs_pkg::CTRL_PARAM_OK] = param_ok_q;
            end
            rofs_pkg::ADDR_PARAM:    rdata_d[23:0]     = param_stage_q;
            rofs_pkg::ADDR_OUTDATA:  rdata_d[N_CH-1:0] = out_data_q;
            // Fresh read-back each scan read
            rofs_pkg::ADDR_READBACK: rdata_d[N_CH-1:0] = o_relay_drive;
            rofs_pkg::ADDR_STATUS: begin
                rdata_d[rofs_pkg::ST_RUNNING] = state_q == rofs_pkg::ROFS_RUN;
                rdata_d[rofs_pkg::ST_FAULT]   = state_q == rofs_pkg::ROFS_FAULT;
                rdata_d[rofs_pkg::ST_OUT_VAL] = out_valid_q;
            end
            rofs_pkg::ADDR_IRQ_STAT: rdata_d[EVW-1:0]  = irq_stat_q;
            rofs_pkg::ADDR_IRQ_MASK: rdata_d[EVW-1:0]  = irq_mask_q;
            rofs_pkg::ADDR_ACTIVE:   rdata_d[23:0]     = param_act_q;
            default:                 rdata_d           = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? rdata_d : 32'h0;
        end
    end
endmodule // rofs_top

// file: dv/rofs_asserts.sv
// Port-level checks for the relay output block
`timescale 1ns/1ps
module rofs_asserts #(
    parameter int          N_CH     = 8,
    parameter logic [31:0] HALF_CYC = 32'd4
) (
    input wire logic            i_core_clk,
    input wire logic            i_rst,
    input wire logic [7:0]      i_addr,
    input wire logic [31:0]     i_wdata,
    input wire logic            i_wr,
    input wire logic            i_rd,
    input wire logic [31:0]     o_rdata,
    input wire logic [N_CH-1:0] o_relay_drive,
    input wire logic [N_CH-1:0] o_ch_led,
    input wire logic            o_link_led,
    input wire logic            o_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic            run_q;  // Link running, shadowed from control writes
    logic            ld_q;   // A good download has happened
    logic            seen_q; // Output data accepted once
    logic [N_CH-1:0] last_q; // Last accepted output data
    logic [31:0]     hold_q; // Cycles since the link LED last moved or the link last ran
    logic            led_q;  // Link LED one cycle ago
    wire good   = i_wr && i_addr == rofs_pkg::ADDR_CTRL && i_wdata[2:0] == 3'h7;
    wire wr_ctl = i_wr && i_addr == rofs_pkg::ADDR_CTRL;
    wire wr_out = i_wr && i_addr == rofs_pkg::ADDR_OUTDATA && run_q;
    // Shadow state; only full downloads may start the link
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            run_q  <= 1'b0;
            ld_q   <= 1'b0;
            seen_q <= 1'b0;
            last_q <= '0;
            hold_q <= '0;
            led_q  <= 1'b0;
        end else begin
            if (wr_ctl) run_q <= i_wdata[0] && (ld_q || good);
            ld_q   <= ld_q || good;
            seen_q <= seen_q || wr_out;
            if (wr_out) last_q <= i_wdata[N_CH-1:0];
            hold_q <= (o_link_led != led_q || run_q) ? 32'h0 : hold_q + 32'h1;
            led_q  <= o_link_led;
        end
    end
    led_mirror_a: assert property (o_ch_led == o_relay_drive)
        else $error("channel LED differs from relay drive");
    relays_quiet_a: assert property (!seen_q |-> o_relay_drive == '0)
        else $error("relay closed before output data");
    scan_follow_a: assert property ($past(wr_out) |-> ##[0:2] o_relay_drive == last_q)
        else $error("relay drive does not follow output data");
    readback_echo_a: assert property (i_rd && i_addr == rofs_pkg::ADDR_READBACK
        |=> o_rdata == 32'($past(o_relay_drive)))
        else $error("read-back differs from relay drive");
    link_steady_a: assert property (run_q && $past(run_q, 4) |-> o_link_led)
        else $error("link LED not steady while running");
    link_blink_a: assert property (!run_q |-> hold_q <= HALF_CYC + 32'd4)
        else $error("link LED not blinking without link");
    reset_quiet_a: assert property ($fell(i_rst) |-> o_relay_drive == '0 && !o_irq)
        else $error("outputs active after reset");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data outside read cycle");
endmodule // rofs_asserts
bind rofs_top rofs_asserts #(.N_CH(N_CH), .HALF_CYC(HALF_CYC)) chk_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_relay_drive(o_relay_drive),
    .o_ch_led(o_ch_led), .o_link_led(o_link_led), .o_irq(o_irq));

// file: dv/rofs_master.sv
// Master controller model driving the register port
`timescale 1ns/1ps
module rofs_master (
    input  wire logic        i_core_clk,
    output logic      [7:0]  o_addr,
    output logic      [31:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    // Idle bus from time zero
    initial begin
        o_addr  = 8'h00;
        o_wdata = 32'h0;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // One-cycle write; data inverted after so no stale value lingers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_core_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask
    // One-cycle read; the bench samples the answer
    task automatic rd(input logic [7:0] a);
        @(posedge i_core_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_core_clk);
        o_rd   <= 1'b0;
    endtask
    // One scan: output data, then read-back
    task automatic scan(input logic [7:0] d);
        wr(rofs_pkg::ADDR_OUTDATA, {24'h0, d});
        repeat (2) @(posedge i_core_clk);
        rd(rofs_pkg::ADDR_READBACK);
    endtask
endmodule // rofs_master

// file: dv/rofs_top_tb.sv
// Self-checking bench for the relay output block
`timescale 1ns/1ps
module rofs_top_tb;
    logic        i_core_clk = 1'b0; // 250 MHz core clock
    logic        i_rst      = 1'b1; // Held for 16 cycles
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [7:0]  relay;
    logic        link_led;
    logic        irq;
    logic [31:0] exp_q[$];          // Noted read results
    logic        rd_q  = 1'b0;      // Read issued last cycle
    logic [15:0] seed  = 16'd54041; // Random source state
    int          err_count = 0;
    int          comparisons = 0;
    initial forever #2 i_core_clk = ~i_core_clk;
    rofs_master m_u (.i_core_clk(i_core_clk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    // Short blink period keeps the run brief
    rofs_top #(.N_CH(8), .HALF_CYC(32'd4)) dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_relay_drive(relay), .o_ch_led(), .o_link_led(link_led), .o_irq(irq));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        m_u.rd(a);
    endtask
    task automatic scanx(input logic [7:0] d);
        exp_q.push_back({24'h0, d});
        m_u.scan(d);
    endtask
    // Blinking means two rises in the span or unlit at the end; steady means lit at the end, at most one rise
    task automatic blink(input logic e);
        int   n;
        logic p;
        n = 0;
        p = link_led;
        repeat (32) begin
            @(posedge i_core_clk);
            if (link_led === 1'b1 && p === 1'b0) n++;
            p = link_led;
        end
        cmp("link_led", {31'h0, e}, {31'h0, n > 1 || link_led !== 1'b1});
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge i_core_clk);
        cmp("irq", {31'h0, e}, {31'h0, irq});
    endtask
    // Read answers are compared one cycle after their strobe
    always @(posedge i_core_clk) begin
        if (rd_q) cmp("rdata", exp_q.pop_front(), rdata);
        rd_q <= rd;
    end
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rdx(rofs_pkg::ADDR_STATUS, 32'h0);
        m_u.wr(rofs_pkg::ADDR_OUTDATA, 32'hff); // Refused before the link runs
        rdx(rofs_pkg::ADDR_READBACK, 32'h0);
        blink(1'b1);
        m_u.wr(rofs_pkg::ADDR_PARAM, 32'h0000a501);
        m_u.wr(rofs_pkg::ADDR_CTRL, 32'h3); // Commit with bad parameters
        blink(1'b1);
        rdx(rofs_pkg::ADDR_IRQ_STAT, 32'h2);
        m_u.wr(rofs_pkg::ADDR_IRQ_MASK, 32'h0);
        irq_is(1'b0);
        m_u.wr(rofs_pkg::ADDR_IRQ_MASK, 32'hf);
        irq_is(1'b1);
        m_u.wr(rofs_pkg::ADDR_IRQ_STAT, 32'hf);
        irq_is(1'b0);
        m_u.wr(rofs_pkg::ADDR_CTRL, 32'h7); // Full download
        blink(1'b0);
        rdx(rofs_pkg::ADDR_ACTIVE, 32'h0000a501);
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            scanx(seed[7:0]);
        end
        rdx(rofs_pkg::ADDR_STATUS, 32'h5);
        m_u.wr(rofs_pkg::ADDR_IRQ_STAT, 32'hf);
        m_u.wr(rofs_pkg::ADDR_PARAM, 32'h0000ff00); // Staged only, not in force
        m_u.wr(rofs_pkg::ADDR_READBACK, 32'h0); // Read-only place
        m_u.wr(8'h24, 32'hffffffff); // Unmapped write
        rdx(8'h20, 32'h0);
        rdx(rofs_pkg::ADDR_ACTIVE, 32'h0000a501);
        rdx(rofs_pkg::ADDR_READBACK, {24'h0, seed[7:0]});
        m_u.wr(rofs_pkg::ADDR_CTRL, 32'h4); // Link lost
        blink(1'b1);
        irq_is(1'b1);
        rdx(rofs_pkg::ADDR_READBACK, 32'ha5);
        m_u.wr(rofs_pkg::ADDR_CTRL, 32'h5); // Link back
        blink(1'b0);
        scanx(8'h3c);
        m_u.wr(rofs_pkg::ADDR_CTRL, 32'h7); // Reload in hold mode
        rdx(rofs_pkg::ADDR_ACTIVE, 32'h0000ff00);
        m_u.wr(rofs_pkg::ADDR_CTRL, 32'h4);
        repeat (4) @(posedge i_core_clk);
        rdx(rofs_pkg::ADDR_READBACK, 32'h3c);
        results();
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (3000) @(posedge i_core_clk);
        err_count++;
        results();
    end
endmodule // rofs_top_tb
